// ==== rtl/cid_pkg.sv ====
package cid_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned BAUD            = 1200;
  localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD;
  localparam int unsigned WORD_BITS       = 8;
  localparam int unsigned SCLK_HALF_NS    = 2000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SCLK_HALF_CYC   = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned TRIG_DELAY_CYC  = 1000;
  localparam logic [7:0]  WORD_RESET      = 8'h00;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_DATA    = 8'h14;

  localparam int unsigned CTRL_SOFT_POWER_DOWN_INPUT = 0;
  localparam int unsigned CTRL_SOFT_DEMOD = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h2;

  localparam int unsigned IRQ_WORD    = 0;
  localparam int unsigned IRQ_TRIG    = 1;
  localparam int unsigned IRQ_CARRIER = 2;
  localparam int unsigned IRQ_BITS    = 3;

  typedef enum logic [1:0] {
    M0_IDLE  = 2'b00,
    M0_HIGH  = 2'b01,
    M0_LOW   = 2'b11
  } cid_m0_state_t;
endpackage

// ==== rtl/cid_sync2.sv ====
`timescale 1ns/1ps
module cid_sync2 (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

// ==== rtl/cid_trig.sv ====
`timescale 1ns/1ps
module cid_trig
  import cid_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic trig_in_s,
  input  wire logic rc_in_s,
  output logic      rc_dis_oe,
  output logic      trigger_output
);
  // Node discharged while input high; output rises once RC node charged
  // (or internal delay expires, for benches without an RC model).
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        out_q;
  logic        out_d;
  logic        dis_q;
  logic        dis_d;

  always_comb begin
    dis_d = trig_in_s;
    cnt_d = cnt_q;
    out_d = out_q;
    if (trig_in_s) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (cnt_q < 16'(TRIG_DELAY_CYC) && !rc_in_s) begin
      cnt_d = cnt_q + 16'h0001;
    end else begin
      out_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_q <= 16'h0000;
      out_q <= 1'b1;
      dis_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
      dis_q <= dis_d;
    end
  end

  assign rc_dis_oe      = dis_q;
  assign trigger_output = out_q;
endmodule

// ==== rtl/cid_top.sv ====
`timescale 1ns/1ps
// Function
// R1 - Mode pin low selects mode 0, high mode 1
// R2 - Shift clock output mode 0, input mode 1
// R3 - Mode 0 bits appear once demodulated
// R4 - Mode 1 shifts bit on host rising edge
// R5 - Power down stops all but trigger path
// R6 - Demodulate only while demod enable high
// R7 - Trigger output rises after RC delay
// R8 - Trigger output flags reversal or ringing
// R9 - Accept 1200 baud demodulated bit stream
// R10 - System supplies timebase clock
// R11 - Word ready low after each 8-bit word
// R12 - Event output low while any source active
// R13 - Carrier present low while in-band signal
// R14 - Host shift clock synchronised before edge detect
module cid_top
  import cid_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        mode_select,
  input  wire logic        power_down_input,
  input  wire logic        demod_enable,
  input  wire logic        trigger_input,
  input  wire logic        trigger_rc_node_in,
  output logic             trigger_rc_node_out,
  output logic             trigger_rc_node_oe,
  output logic             trigger_output,
  input  wire logic        serial_shift_clock_in,
  output logic             serial_shift_clock_out,
  output logic             serial_shift_clock_oe,
  output logic             serial_data,
  output logic             word_ready_n,
  output logic             carrier_present_n,
  output logic             event_n_out,
  output logic             event_n_oe,
  input  wire logic        demod_bit,
  input  wire logic        demod_bit_valid,
  input  wire logic        inband_present,
  input  wire logic        tone_detect_delayed,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  import cid_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic mode_s;
  logic power_down_input_s;
  logic den_s;
  logic trig_s;
  logic rc_s;
  logic sclk_s;

  cid_sync2 u_sync_mode (.clock(clock), .srst(srst), .din(mode_select), .dout(mode_s));
  cid_sync2 u_sync_power_down_input (.clock(clock), .srst(srst), .din(power_down_input), .dout(power_down_input_s));
  cid_sync2 u_sync_den  (.clock(clock), .srst(srst), .din(demod_enable), .dout(den_s));
  cid_sync2 u_sync_trig (.clock(clock), .srst(srst), .din(trigger_input), .dout(trig_s));
  cid_sync2 u_sync_rc   (.clock(clock), .srst(srst), .din(trigger_rc_node_in), .dout(rc_s));
  cid_sync2 u_sync_sclk (.clock(clock), .srst(srst), .din(serial_shift_clock_in), .dout(sclk_s)); // see R14

  // ----------------------------------------------------------------
  // Trigger path, alive during power down
  // ----------------------------------------------------------------
  cid_trig u_trig (
    .clock          (clock),
    .srst           (srst),
    .trig_in_s      (trig_s),
    .rc_in_s        (rc_s),
    .rc_dis_oe      (trigger_rc_node_oe),
    .trigger_output (trigger_output)
  ); // see R7 see R8
  assign trigger_rc_node_out = 1'b0;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [1:0]          ctrl_q,    ctrl_d;
  logic [IRQ_BITS-1:0] ist_q,     ist_d;
  logic [IRQ_BITS-1:0] ien_q,     ien_d;
  logic [7:0]          shreg_q,   shreg_d;
  logic [7:0]          word_q,    word_d;
  logic [3:0]          nbits_q,   nbits_d;
  logic                sdata_q,   sdata_d;
  logic                wrdy_q,    wrdy_d;
  logic                sclk_q,    sclk_d;
  logic                sclk_p_q,  sclk_p_d;
  logic [15:0]         tmr_q,     tmr_d;
  logic                pend_q,    pend_d;
  logic                pbit_q,    pbit_d;
  logic                trig_p_q,  trig_p_d;
  logic                cd_p_q,    cd_p_d;
  cid_m0_state_t       st_q,      st_d;

  logic active;
  logic mode1;
  logic bit_in;
  logic host_rise;
  logic wr_en;
  logic rd_en;
  logic word_done;

  assign mode1     = mode_s;                                              // see R1
  assign active    = !power_down_input_s && !ctrl_q[CTRL_SOFT_POWER_DOWN_INPUT];                  // see R5
  // The upstream strobe arrives once per 1200 baud bit from our own clock
  assign bit_in    = active && den_s && ctrl_q[CTRL_SOFT_DEMOD] && demod_bit_valid; // see R6 see R9
  assign host_rise = sclk_s && !sclk_p_q;                                 // see R4
  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;

  // ----------------------------------------------------------------
  // Serial output engine
  // ----------------------------------------------------------------
  always_comb begin
    shreg_d   = shreg_q;
    word_d    = word_q;
    nbits_d   = nbits_q;
    sdata_d   = sdata_q;
    wrdy_d    = wrdy_q;
    sclk_d    = sclk_q;
    sclk_p_d  = sclk_s;
    tmr_d     = tmr_q;
    pend_d    = pend_q;
    pbit_d    = pbit_q;
    st_d      = st_q;
    word_done = 1'b0;
    if (!active) begin
      nbits_d = 4'h0;
      wrdy_d  = 1'b0;
      sclk_d  = 1'b0;
      pend_d  = 1'b0;
      st_d    = M0_IDLE;
    end else if (!mode1) begin
      // Mode 0: bit goes straight to the pin, then one clock pulse
      if (bit_in) begin
        sdata_d = demod_bit;                                              // see R3
        pend_d  = 1'b1;
        pbit_d  = demod_bit;
      end
      case (st_q)
        M0_IDLE: begin
          if (pend_q) begin
            pend_d  = bit_in;
            sclk_d  = 1'b1;
            tmr_d   = 16'(SCLK_HALF_CYC);
            st_d    = M0_HIGH;
            if (nbits_q == 4'h0) begin
              wrdy_d = 1'b0;
            end
            shreg_d = {pbit_q, shreg_q[7:1]};
          end
        end
        M0_HIGH: begin
          if (tmr_q == 16'h0000) begin
            sclk_d = 1'b0;
            tmr_d  = 16'(SCLK_HALF_CYC);
            st_d   = M0_LOW;
          end else begin
            tmr_d = tmr_q - 16'h0001;
          end
        end
        M0_LOW: begin
          if (tmr_q == 16'h0000) begin
            st_d = M0_IDLE;
            if (nbits_q == 4'(WORD_BITS - 1)) begin
              nbits_d   = 4'h0;
              word_d    = shreg_q;
              wrdy_d    = 1'b1;                                           // see R11
              word_done = 1'b1;
            end else begin
              nbits_d = nbits_q + 4'h1;
            end
          end else begin
            tmr_d = tmr_q - 16'h0001;
          end
        end
        default: st_d = M0_IDLE;
      endcase
    end else begin
      // Mode 1: collect a word, then host clocks it out
      sclk_d = 1'b0;
      st_d   = M0_IDLE;
      if (!wrdy_q) begin
        if (bit_in) begin
          shreg_d = {demod_bit, shreg_q[7:1]};
          if (nbits_q == 4'(WORD_BITS - 1)) begin
            nbits_d   = 4'h0;
            wrdy_d    = 1'b1;                                             // see R11
            word_d    = {demod_bit, shreg_q[7:1]};
            word_done = 1'b1;
          end else begin
            nbits_d = nbits_q + 4'h1;
          end
        end
      end else if (host_rise) begin
        sdata_d = word_q[0];                                              // see R4
        word_d  = {1'b0, word_q[7:1]};
        if (nbits_q == 4'(WORD_BITS - 1)) begin
          nbits_d = 4'h0;
          wrdy_d  = 1'b0;
        end else begin
          nbits_d = nbits_q + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // APB registers and interrupts
  // ----------------------------------------------------------------
  logic [IRQ_BITS-1:0] ev;
  assign ev[IRQ_WORD]    = word_done;
  assign ev[IRQ_TRIG]    = trigger_output && !trig_p_q;
  assign ev[IRQ_CARRIER] = active && inband_present && !cd_p_q;

  always_comb begin
    ctrl_d   = ctrl_q;
    ien_d    = ien_q;
    ist_d    = ist_q;
    trig_p_d = trigger_output;
    cd_p_d   = active && inband_present;
    if (wr_en && paddr == ADDR_CTRL) begin
      ctrl_d = pwdata[1:0];
    end
    if (wr_en && paddr == ADDR_IRQ_EN) begin
      ien_d = pwdata[IRQ_BITS-1:0];
    end
    if (wr_en && paddr == ADDR_IRQ_CLR) begin
      ist_d = ist_q & ~pwdata[IRQ_BITS-1:0];
    end
    // Set beats a clear landing in the same cycle
    ist_d = ist_d | ev;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        ADDR_CTRL:   prdata = {30'h0, ctrl_q};
        ADDR_STATUS: prdata = {25'h0, power_down_input_s, mode1, trigger_output, !carrier_present_n,
                               !word_ready_n, nbits_q[1:0]};
        ADDR_IRQ_ST: prdata = {29'h0, ist_q};
        ADDR_IRQ_EN: prdata = {29'h0, ien_q};
        ADDR_DATA:   prdata = {24'h0, word_q};
        default:     prdata = 32'h0000_0000;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
                   paddr == ADDR_IRQ_ST || paddr == ADDR_IRQ_EN || paddr == ADDR_IRQ_CLR ||
                   paddr == ADDR_DATA);
  assign irq     = |(ist_q & ien_q);

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q   <= CTRL_RESET;
      ist_q    <= '0;
      ien_q    <= '0;
      shreg_q  <= WORD_RESET;
      word_q   <= WORD_RESET;
      nbits_q  <= 4'h0;
      sdata_q  <= 1'b0;
      wrdy_q   <= 1'b0;
      sclk_q   <= 1'b0;
      sclk_p_q <= 1'b0;
      tmr_q    <= 16'h0000;
      pend_q   <= 1'b0;
      pbit_q   <= 1'b0;
      trig_p_q <= 1'b1;
      cd_p_q   <= 1'b0;
      st_q     <= M0_IDLE;
    end else begin
      ctrl_q   <= ctrl_d;
      ist_q    <= ist_d;
      ien_q    <= ien_d;
      shreg_q  <= shreg_d;
      word_q   <= word_d;
      nbits_q  <= nbits_d;
      sdata_q  <= sdata_d;
      wrdy_q   <= wrdy_d;
      sclk_q   <= sclk_d;
      sclk_p_q <= sclk_p_d;
      tmr_q    <= tmr_d;
      pend_q   <= pend_d;
      pbit_q   <= pbit_d;
      trig_p_q <= trig_p_d;
      cd_p_q   <= cd_p_d;
      st_q     <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign serial_shift_clock_out = sclk_q;
  assign serial_shift_clock_oe  = active && !mode1;                      // see R2
  assign serial_data            = sdata_q;
  assign word_ready_n           = !wrdy_q;
  assign carrier_present_n      = !(active && inband_present);            // see R13
  assign event_n_out            = 1'b0;
  // Open drain: pull low while any event source is active
  assign event_n_oe             = !trigger_output || wrdy_q || (active && tone_detect_delayed); // see R12
endmodule

// ==== tb/cid_chk.sv ====
`timescale 1ns/1ps
module cid_chk
  import cid_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic mode_select,
  input wire logic power_down_input,
  input wire logic demod_enable,
  input wire logic trigger_input,
  input wire logic trigger_rc_node_in,
  input wire logic trigger_output,
  input wire logic serial_shift_clock_out,
  input wire logic serial_shift_clock_oe,
  input wire logic serial_data,
  input wire logic word_ready_n,
  input wire logic carrier_present_n,
  input wire logic event_n_oe,
  input wire logic demod_bit,
  input wire logic demod_bit_valid,
  input wire logic inband_present,
  input wire logic tone_detect_delayed,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Shadow of the soft control bits, so pin-level checks skip a soft power down
  logic [1:0] soft_q;
  logic [1:0] soft_d;
  always_comb begin
    soft_d = soft_q;
    if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
      soft_d = pwdata[1:0];
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      soft_q <= CTRL_RESET;
    end else begin
      soft_q <= soft_d;
    end
  end
  // ----------------------------------------
  // Pins sit behind two-stage synchronisers, hence the four-cycle settle
  // ----------------------------------------
  dev_clk_a: assert property ((!mode_select && !power_down_input && !soft_q[CTRL_SOFT_POWER_DOWN_INPUT])[*4]
    |-> serial_shift_clock_oe)
    else $error("shift clock not driven in mode 0");
  host_clk_a: assert property (mode_select[*4] |-> !serial_shift_clock_oe)
    else $error("shift clock driven in mode 1");
  bit_out_a: assert property ((!mode_select && !power_down_input && demod_enable && !soft_q[CTRL_SOFT_POWER_DOWN_INPUT]
    && soft_q[CTRL_SOFT_DEMOD])[*4] ##0 demod_bit_valid |=> serial_data == $past(demod_bit))
    else $error("demodulated bit not presented");
  power_down_input_quiet_a: assert property (power_down_input[*4] |-> !serial_shift_clock_oe && carrier_present_n)
    else $error("outputs active in power down");
  trig_low_a: assert property (trigger_input[*4] |-> !trigger_output)
    else $error("trigger output high during event");
  trig_wait_a: assert property (trigger_input[*4] ##1 (!trigger_input && !trigger_rc_node_in)[*8]
    |-> !trigger_output)
    else $error("trigger output rose before delay");
  word_edge_a: assert property ((!mode_select)[*4] ##0 $fell(word_ready_n) |-> !serial_shift_clock_out)
    else $error("word ready fell outside low phase");
  event_on_a: assert property ((!trigger_output || !word_ready_n) |-> event_n_oe)
    else $error("event output not asserted");
  event_off_a: assert property ((trigger_output && word_ready_n && !tone_detect_delayed) |-> !event_n_oe)
    else $error("event output stuck");
  no_carrier_a: assert property (!inband_present |-> carrier_present_n)
    else $error("carrier flagged without signal");
  cover property ($fell(word_ready_n));
  cover property ($rose(trigger_output));
  cover property (mode_select && $rose(word_ready_n));
endmodule

bind cid_top cid_chk cid_chk_i (.clock, .srst, .mode_select, .power_down_input, .demod_enable, .trigger_input,
  .trigger_rc_node_in, .trigger_output, .serial_shift_clock_out, .serial_shift_clock_oe, .serial_data,
  .word_ready_n, .carrier_present_n, .event_n_oe, .demod_bit, .demod_bit_valid, .inband_present,
  .tone_detect_delayed, .psel, .penable, .pwrite, .paddr, .pwdata);

// ==== tb/cid_host.sv ====
`timescale 1ns/1ps
module cid_host (
  input  wire logic       go,
  input  wire logic       serial_data,
  output logic            sclk,
  output logic [7:0]      word,
  output logic            done
);
  initial begin
    sclk = 1'b0;
    word = 8'h00;
    done = 1'b0;
  end
  // Link clock stands still between frames; its phase is unrelated to the block clock
  always @(posedge go) begin
    done = 1'b0;
    #7;
    for (int i = 0; i < 8; i++) begin
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
      // Sample late, just before the next rise, as the block answers a few cycles after each edge
      #40;
      word[i] = serial_data;
    end
    done = 1'b1;
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import cid_pkg::*;
  logic        clock, srst, mode_select, power_down_input, demod_enable, trigger_input, rc_q, go, err;
  logic        demod_bit, demod_bit_valid, inband_present, tone_detect_delayed, psel, penable, pwrite;
  logic        rc_oe, rc_out, sclk_out, sclk_oe, sclk_host, sdata, wr_n, cp_n, ev_out, ev_oe, trig_out;
  logic        pready, pslverr, irq, host_done;
  logic [7:0]  paddr, host_word;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, n_compared, rc_cnt;

  cid_top cid_top_i (.clock, .srst, .mode_select, .power_down_input, .demod_enable, .trigger_input,
    .trigger_rc_node_in(rc_oe ? 1'b0 : rc_q), .trigger_rc_node_out(rc_out), .trigger_rc_node_oe(rc_oe),
    .trigger_output(trig_out), .serial_shift_clock_in(sclk_oe ? sclk_out : sclk_host),
    .serial_shift_clock_out(sclk_out), .serial_shift_clock_oe(sclk_oe), .serial_data(sdata),
    .word_ready_n(wr_n), .carrier_present_n(cp_n), .event_n_out(ev_out), .event_n_oe(ev_oe), .demod_bit,
    .demod_bit_valid, .inband_present, .tone_detect_delayed, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq);
  cid_host cid_host_i (.go, .serial_data(sdata), .sclk(sclk_host), .word(host_word), .done(host_done));

  // RC node charges through its resistor some 2 us after the discharge is let go
  always @(posedge clock) begin
    rc_cnt <= (rc_oe !== 1'b0) ? 0 : rc_cnt + 1;
    rc_q   <= (rc_oe === 1'b0) && rc_cnt >= 200;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic do_reset(input logic m);
    srst        <= 1'b1;
    mode_select <= m;
    cyc(10);
    srst        <= 1'b0;
    cyc(5);
  endtask
  task automatic send_bit(input logic b);
    demod_bit       <= b;
    demod_bit_valid <= 1'b1;
    @(posedge clock);
    demod_bit_valid <= 1'b0;
    cyc(3);
  endtask
  task automatic send_word(input logic [7:0] w);
    for (int i = 0; i < 8; i++) begin
      chk("word_ready_n", 1, wr_n);
      send_bit(w[i]);
      // In mode 1 the data pin keeps its reset level until the host clocks
      chk("serial_data", mode_select ? 1'b0 : w[i], sdata);
      chk("sclk_out", !mode_select, sclk_out);
      cyc(480);
    end
  endtask

  task automatic t_regs;
    do_reset(0);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl", {30'h0, CTRL_RESET}, rd);
    apb(0, 8'h20, 0);
    chk("unmapped", 0, rd);
    chk("pslverr", 1, err);
    $display("done regs");
  endtask
  task automatic t_mode0;
    do_reset(0);
    apb(1, ADDR_IRQ_EN, 32'h1);
    chk("sclk_oe", 1, sclk_oe);
    send_word(8'hA5);
    chk("word_ready_n", 0, wr_n);
    chk("irq", 1, irq);
    apb(1, ADDR_IRQ_EN, 0);
    chk("irq masked", 0, irq);
    apb(1, ADDR_IRQ_CLR, 32'h1);
    apb(1, ADDR_IRQ_EN, 32'h1);
    chk("irq cleared", 0, irq);
    $display("done mode0");
  endtask
  task automatic t_mode1;
    do_reset(1);
    chk("sclk_oe", 0, sclk_oe);
    apb(0, ADDR_STATUS, 0);
    chk("mode1 status", 1, rd[5]);
    send_word(8'h3C);
    chk("word_ready_n", 0, wr_n);
    go <= 1'b1;
    cyc(2);
    for (int k = 0; k < 200 && host_done !== 1'b1; k++) @(posedge clock);
    go <= 1'b0;
    chk("host_done", 1, host_done);
    chk("host word", 8'h3C, host_word);
    chk("word_ready_n", 1, wr_n);
    $display("done mode1");
  endtask
  task automatic t_gate;
    do_reset(0);
    demod_enable     <= 1'b0;
    cyc(4);
    send_bit(1'b1);
    chk("serial_data", 0, sdata);
    demod_enable     <= 1'b1;
    power_down_input <= 1'b1;
    inband_present   <= 1'b1;
    cyc(5);
    send_bit(1'b1);
    chk("serial_data", 0, sdata);
    chk("carrier_present_n", 1, cp_n);
    power_down_input <= 1'b0;
    cyc(5);
    chk("carrier_present_n", 0, cp_n);
    inband_present   <= 1'b0;
    send_bit(1'b1);
    chk("serial_data", 1, sdata);
    apb(1, ADDR_CTRL, 32'h0);
    send_bit(1'b0);
    chk("serial_data", 1, sdata);
    apb(1, ADDR_CTRL, 32'h1);
    chk("sclk_oe", 0, sclk_oe);
    apb(1, ADDR_CTRL, {30'h0, CTRL_RESET});
    $display("done gating");
  endtask
  task automatic t_trig;
    do_reset(0);
    trigger_input       <= 1'b1;
    cyc(10);
    chk("trigger_output", 0, trig_out);
    chk("rc_oe", 1, rc_oe);
    chk("event_n_oe", 1, ev_oe);
    trigger_input       <= 1'b0;
    cyc(100);
    chk("trigger_output", 0, trig_out);
    cyc(200);
    chk("trigger_output", 1, trig_out);
    chk("event_n_oe", 0, ev_oe);
    tone_detect_delayed <= 1'b1;
    cyc(2);
    chk("event_n_oe", 1, ev_oe);
    tone_detect_delayed <= 1'b0;
    chk("rc_oe", 0, rc_oe);
    chk("rc_out", 0, rc_out);
    chk("event_n_out", 0, ev_out);
    $display("done trigger");
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #300_000;
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    {srst, mode_select, power_down_input, trigger_input, go, demod_bit, demod_bit_valid} = 7'h40;
    {inband_present, tone_detect_delayed, psel, penable, pwrite} = 5'h00;
    demod_enable = 1'b1;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    @(posedge clock);
    t_regs();
    t_mode0();
    t_mode1();
    t_gate();
    t_trig();
    wrap_up();
  end
endmodule
